// ==== common/smb_pkg.sv ====
package smb_pkg;

    // ------------------------------------------------------------
    // slave address and command codes
    // ------------------------------------------------------------
    localparam logic [4:0] SLAVE_ADDR_HI  = 5'h05;
    localparam logic [7:0] RAM_LAST       = 8'hDF;
    localparam int         RAM_DEPTH      = 224;
    localparam logic [7:0] NV_HI_FIRST    = 8'hF8;
    localparam logic [7:0] NV_HI_LAST     = 8'hFB;
    localparam logic [7:0] CMD_BLOCK_WR   = 8'hFC;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'hFE;

    // ------------------------------------------------------------
    // config_update_control register
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR         = 8'h90;
    localparam int         CFG_ERASE_EN_BIT = 2;
    localparam logic [7:0] CFG_RESET        = 8'h00;

    // ------------------------------------------------------------
    // nonvolatile array layout
    // ------------------------------------------------------------
    localparam int         NV_ADDR_W  = 10;
    localparam int         NV_DEPTH   = 1024;
    localparam int         PAGE_BITS  = 5;
    localparam int         PAGE_BYTES = 32;
    localparam logic [7:0] NV_BLANK   = 8'hFF;

    // ------------------------------------------------------------
    // bus framing and timing
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0] ACK_BIT          = 4'h9;
    localparam int         CLK_PERIOD_PS    = 10000;
    localparam int         ERASE_TIME_MS    = 20;
    // one ms is 1e9 ps; divide first so the product stays inside 32 bits
    localparam int         ERASE_CYCLES     = ERASE_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    localparam logic [15:0] PTR_RESET       = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WR,
        ST_RD,
        ST_RD_ACK,
        ST_RD_NEXT,
        ST_IGNORE
    } phase_t;

endpackage

// ==== common/nv_if.sv ====
`timescale 1ns/10ps
interface nv_if;
    logic                         prog_req;
    logic                         erase_req;
    logic [smb_pkg::NV_ADDR_W-1:0] addr;
    logic [7:0]                   wdata;
    logic [7:0]                   rdata;
    logic                         busy;

    modport ctrl  (output prog_req, erase_req, addr, wdata, input rdata, busy);
    modport store (input prog_req, erase_req, addr, wdata, output rdata, busy);
endinterface

// ==== src/scl_shifter.sv ====
`timescale 1ns/10ps
module scl_shifter (
    // link clock and data
    input  wire logic       scl_clk_i,
    input  wire logic       sda_i,
    // received byte, stable from 8th rising edge until the next one
    output logic [7:0]      word_o
);
    always_ff @(posedge scl_clk_i) begin
        word_o <= {word_o[6:0], sda_i};
    end
endmodule // scl_shifter

// ==== src/nv_store.sv ====
`timescale 1ns/10ps
module nv_store #(
    parameter int ERASE_CYCLES = smb_pkg::ERASE_CYCLES
) (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    nv_if.store       nv
);
    logic [7:0]  mem [0:smb_pkg::NV_DEPTH-1];
    logic [21:0] erase_cnt_r;

    assign nv.rdata = mem[nv.addr];
    assign nv.busy  = (erase_cnt_r != 22'h000000);

    // ------------------------------------------------------------
    // erase timer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            erase_cnt_r <= 22'h000000;
        end else if (ce_i) begin
            if (nv.erase_req && !nv.busy) begin
                erase_cnt_r <= 22'(ERASE_CYCLES);
            end else if (nv.busy) begin
                erase_cnt_r <= erase_cnt_r - 22'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // array: bytes only program while blank, whole pages erase
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            if (nv.erase_req && !nv.busy) begin
                for (int i = 0; i < smb_pkg::PAGE_BYTES; i++) begin
                    mem[{nv.addr[smb_pkg::NV_ADDR_W-1:smb_pkg::PAGE_BITS], 5'(i)}]
                        <= smb_pkg::NV_BLANK;
                end
            end else if (nv.prog_req && !nv.busy && mem[nv.addr] == smb_pkg::NV_BLANK) begin
                mem[nv.addr] <= nv.wdata;
            end
        end
    end
endmodule // nv_store

// ==== src/smbus_ram_nv_slave.sv ====
`timescale 1ns/10ps
module smbus_ram_nv_slave #(
    parameter int ERASE_CYCLES = smb_pkg::ERASE_CYCLES
) (
    // clock, reset, enable
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    // bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // address select pins
    input  wire logic       address_select_high_pin_i,
    input  wire logic       address_select_low_pin_i,
    // device status
    input  wire logic       download_done_i,
    output logic            erase_busy_o,
    output logic [7:0]      config_update_control_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]      scl_s;
        logic [2:0]      sda_s;
        logic [1:0]      ahi_s;
        logic [1:0]      alo_s;
        smb_pkg::phase_t st;
        logic [3:0]      bitc;
        logic [1:0]      idx;
        logic [7:0]      cmd;
        logic            rw;
        logic            blk;
        logic [15:0]     ptr;
        logic            ptr_nv;
        logic [7:0]      tx;
        logic            sda_oe;
        logic [7:0]      cfg;
        logic            erase_req;
        logic            prog_req;
        logic [7:0]      nv_wdata;
        logic            ram_we;
        logic [7:0]      ram_waddr;
        logic [7:0]      ram_wdata;
        logic            busy;
    } state_t;

    state_t     s_r;
    state_t     s_nxt;
    logic [7:0] ram [0:smb_pkg::RAM_DEPTH-1];
    logic [7:0] link_word;
    logic [7:0] rd_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       addr_hit;

    nv_if nv ();

    // ------------------------------------------------------------
    // link domain and storage
    // ------------------------------------------------------------
    scl_shifter u_shift (
        .scl_clk_i (scl_i),
        .sda_i     (sda_i),
        .word_o    (link_word)
    );

    nv_store #(
        .ERASE_CYCLES (ERASE_CYCLES)
    ) u_nv (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .nv        (nv)
    );

    assign nv.prog_req  = s_r.prog_req;
    assign nv.erase_req = s_r.erase_req;
    assign nv.addr      = s_r.ptr[smb_pkg::NV_ADDR_W-1:0];
    assign nv.wdata     = s_r.nv_wdata;

    // ------------------------------------------------------------
    // pin event decode on synchronised copies
    // ------------------------------------------------------------
    assign scl_rise   = s_r.scl_s[1] & ~s_r.scl_s[2];
    assign scl_fall   = ~s_r.scl_s[1] & s_r.scl_s[2];
    assign start_cond = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[1] & s_r.sda_s[2];
    assign stop_cond  = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[1] & ~s_r.sda_s[2];

    // link_word is only read after the 8th rise, when the shifter holds still
    assign addr_hit = (link_word[7:1] == {smb_pkg::SLAVE_ADDR_HI, s_r.ahi_s[1], s_r.alo_s[1]})
                      && download_done_i
                      && !s_r.busy;

    // read source follows the most recently set pointer
    always_comb begin
        if (s_r.ptr_nv) begin
            rd_data = nv.rdata;
        end else if (s_r.ptr[7:0] == smb_pkg::CFG_ADDR) begin
            rd_data = s_r.cfg;
        end else if (s_r.ptr[7:0] <= smb_pkg::RAM_LAST) begin
            rd_data = ram[s_r.ptr[7:0]];
        end else begin
            rd_data = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt           = s_r;
        s_nxt.scl_s     = {s_r.scl_s[1:0], scl_i};
        s_nxt.sda_s     = {s_r.sda_s[1:0], sda_i};
        s_nxt.ahi_s     = {s_r.ahi_s[0], address_select_high_pin_i};
        s_nxt.alo_s     = {s_r.alo_s[0], address_select_low_pin_i};
        s_nxt.erase_req = 1'b0;
        s_nxt.prog_req  = 1'b0;
        s_nxt.ram_we    = 1'b0;
        s_nxt.busy      = nv.busy;

        if (start_cond) begin
            // repeated start also lands here
            s_nxt.st     = smb_pkg::ST_ADDR;
            s_nxt.bitc   = 4'h0;
            s_nxt.idx    = 2'b00;
            s_nxt.blk    = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_cond) begin
            s_nxt.st     = smb_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else begin
            case (s_r.st)
                smb_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        s_nxt.bitc = s_r.bitc + 4'h1;
                    end else if (scl_fall && s_r.bitc == smb_pkg::BITS_PER_BYTE) begin
                        s_nxt.rw = link_word[0];
                        if (addr_hit) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.st     = smb_pkg::ST_ACK;
                        end else begin
                            s_nxt.st = smb_pkg::ST_IGNORE;
                        end
                    end
                end
                smb_pkg::ST_ACK: begin
                    if (scl_rise) begin
                        s_nxt.bitc = smb_pkg::ACK_BIT;
                    end else if (scl_fall && s_r.bitc == smb_pkg::ACK_BIT) begin
                        s_nxt.bitc = 4'h0;
                        if (s_r.rw) begin
                            s_nxt.tx     = rd_data;
                            s_nxt.sda_oe = ~rd_data[7];
                            s_nxt.st     = smb_pkg::ST_RD;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = smb_pkg::ST_WR;
                        end
                    end
                end
                smb_pkg::ST_WR: begin
                    if (scl_rise) begin
                        s_nxt.bitc = s_r.bitc + 4'h1;
                        // step on the first bit of the next block byte, so the
                        // nonvolatile address still holds during the program pulse
                        if (s_r.blk && s_r.idx == 2'b11 && s_r.bitc == 4'h0) begin
                            s_nxt.ptr = s_r.ptr + 16'h0001;
                        end
                    end else if (scl_fall && s_r.bitc == smb_pkg::BITS_PER_BYTE) begin
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st     = smb_pkg::ST_ACK;
                        if (s_r.idx != 2'b11) begin
                            s_nxt.idx = s_r.idx + 2'b01;
                        end
                        case (s_r.idx)
                            2'b00: begin
                                s_nxt.cmd = link_word;
                                if (link_word <= smb_pkg::RAM_LAST
                                    || link_word == smb_pkg::CFG_ADDR) begin
                                    s_nxt.ptr    = {8'h00, link_word};
                                    s_nxt.ptr_nv = 1'b0;
                                end else if (link_word == smb_pkg::CMD_PAGE_ERASE) begin
                                    // no enable or no nonvolatile page chosen: nothing happens
                                    s_nxt.erase_req = s_r.cfg[smb_pkg::CFG_ERASE_EN_BIT]
                                                      && s_r.ptr_nv;
                                end else if (link_word == smb_pkg::CMD_BLOCK_WR) begin
                                    s_nxt.blk = 1'b1;
                                end
                            end
                            2'b01: begin
                                if (s_r.blk) begin
                                    // byte count is taken but not enforced; stop ends the block
                                    s_nxt.blk = 1'b1;
                                end else if (s_r.cmd == smb_pkg::CFG_ADDR) begin
                                    s_nxt.cfg = link_word;
                                end else if (s_r.cmd <= smb_pkg::RAM_LAST) begin
                                    s_nxt.ram_we    = 1'b1;
                                    s_nxt.ram_waddr = s_r.cmd;
                                    s_nxt.ram_wdata = link_word;
                                end else if (s_r.cmd >= smb_pkg::NV_HI_FIRST
                                             && s_r.cmd <= smb_pkg::NV_HI_LAST) begin
                                    s_nxt.ptr    = {s_r.cmd, link_word};
                                    s_nxt.ptr_nv = 1'b1;
                                end
                            end
                            default: begin
                                if (s_r.blk || (s_r.idx == 2'b10 && s_r.ptr_nv
                                    && s_r.cmd >= smb_pkg::NV_HI_FIRST
                                    && s_r.cmd <= smb_pkg::NV_HI_LAST)) begin
                                    if (s_r.ptr_nv) begin
                                        s_nxt.prog_req = 1'b1;
                                        s_nxt.nv_wdata = link_word;
                                    end else if (s_r.ptr[7:0] == smb_pkg::CFG_ADDR) begin
                                        s_nxt.cfg = link_word;
                                    end else if (s_r.ptr[7:0] <= smb_pkg::RAM_LAST) begin
                                        s_nxt.ram_we    = 1'b1;
                                        s_nxt.ram_waddr = s_r.ptr[7:0];
                                        s_nxt.ram_wdata = link_word;
                                    end
                                end
                            end
                        endcase
                    end
                end
                smb_pkg::ST_RD: begin
                    if (scl_rise) begin
                        s_nxt.bitc = s_r.bitc + 4'h1;
                    end else if (scl_fall) begin
                        if (s_r.bitc < smb_pkg::BITS_PER_BYTE) begin
                            s_nxt.sda_oe = ~s_r.tx[3'(4'h7 - s_r.bitc)];
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = smb_pkg::ST_RD_ACK;
                        end
                    end
                end
                smb_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (s_r.sda_s[1]) begin
                            s_nxt.st = smb_pkg::ST_IGNORE;
                        end else begin
                            s_nxt.ptr = s_r.ptr + 16'h0001;
                            s_nxt.st  = smb_pkg::ST_RD_NEXT;
                        end
                    end
                end
                smb_pkg::ST_RD_NEXT: begin
                    if (scl_fall) begin
                        s_nxt.tx     = rd_data;
                        s_nxt.sda_oe = ~rd_data[7];
                        s_nxt.bitc   = 4'h0;
                        s_nxt.st     = smb_pkg::ST_RD;
                    end
                end
                smb_pkg::ST_IDLE,
                smb_pkg::ST_IGNORE: begin
                    s_nxt.sda_oe = 1'b0;
                end
                default: begin
                    s_nxt.st     = smb_pkg::ST_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_r        <= '0;
            s_r.scl_s  <= 3'h7;
            s_r.sda_s  <= 3'h7;
            s_r.st     <= smb_pkg::ST_IDLE;
            s_r.ptr    <= smb_pkg::PTR_RESET;
            s_r.cfg    <= smb_pkg::CFG_RESET;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // ram is not reset: its contents come only from bus writes
    always_ff @(posedge ref_clk_i) begin
        if (ce_i && s_r.ram_we) begin
            ram[s_r.ram_waddr] <= s_r.ram_wdata;
        end
    end

    assign sda_o                   = 1'b0;
    assign sda_oe_o                = s_r.sda_oe;
    assign erase_busy_o            = s_r.busy;
    assign config_update_control_o = s_r.cfg;

endmodule // smbus_ram_nv_slave

// ==== verification/smb_slave_checker.sv ====
`timescale 1ns/10ps
module smb_slave_checker #(
    parameter int ERASE_CYCLES = 200
) (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    // watched pins
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe_o,
    input wire logic       download_done_i,
    input wire logic       erase_busy_o,
    input wire logic [7:0] config_update_control_o
);
    // ----------
    // erase length counter
    // ----------
    int busy_cnt_r;
    always_ff @(posedge ref_clk_i) begin
        busy_cnt_r <= (sys_rst_i || !erase_busy_o) ? 0 : busy_cnt_r + 1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence stop_seq;
        scl_i && $rose(sda_i);
    endsequence
    sequence released_seq;
        !sda_oe_o [*4];
    endsequence
    a_reset_clears: assert property (
        $fell(sys_rst_i) |-> !sda_oe_o && !erase_busy_o && config_update_control_o == 8'h00)
        else $error("state not cleared by reset");
    a_nack_no_download: assert property (
        !download_done_i [*3] |-> !sda_oe_o) else $error("drive before download done");
    a_oe_scl_low: assert property (
        $changed(sda_oe_o) |-> !$past(scl_i)) else $error("sda changed while scl high");
    a_stop_release: assert property (
        stop_seq |=> released_seq) else $error("sda driven after stop");
    a_bit_stands: assert property (
        $rose(sda_oe_o) |-> sda_oe_o [*5]) else $error("ack or data bit too short");
    a_erase_enabled: assert property (
        $rose(erase_busy_o) |-> config_update_control_o[2]) else $error("erase while disabled");
    a_erase_length: assert property (
        $fell(erase_busy_o) |-> busy_cnt_r >= ERASE_CYCLES - 2 && busy_cnt_r <= ERASE_CYCLES + 2)
        else $error("erase length wrong");
    a_busy_nack: assert property (
        busy_cnt_r > 30 |-> !sda_oe_o) else $error("ack during erase");
    a_cfg_write_acked: assert property (
        $changed(config_update_control_o) |-> ##[0:4] sda_oe_o) else $error("config unacked");
endmodule // smb_slave_checker

bind smbus_ram_nv_slave smb_slave_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk (
    .ref_clk_i              (ref_clk_i),
    .sys_rst_i              (sys_rst_i),
    .scl_i                  (scl_i),
    .sda_i                  (sda_i),
    .sda_oe_o               (sda_oe_o),
    .download_done_i        (download_done_i),
    .erase_busy_o           (erase_busy_o),
    .config_update_control_o(config_update_control_o)
);

// ==== verification/smb_master_model.sv ====
`timescale 1ns/10ps
module smb_master_model (
    // resolved bus data
    input  wire logic sda_i,
    // driven pins
    output logic      scl_o,
    output logic      sda_low_o
);
    // ----------
    // bit level, quarter of a 64 ns link period
    // ----------
    localparam int Q = 16;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic put_bit(input logic b);
        sda_low_o = !b;
        #Q scl_o = 1'b1;
        #(2*Q) scl_o = 1'b0;
        #Q;
    endtask
    task automatic get_bit(output logic b);
        sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q b = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic start_cond();
        sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop_cond();
        sda_low_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b0;
        #(4*Q);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask
    // last byte released so the device sees a not-acknowledge
    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule // smb_master_model

// ==== verification/smbus_ram_eeprom_access_slave_test.sv ====
`timescale 1ns/10ps
module smbus_ram_eeprom_access_slave_test;
    logic       ref_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       download_done_i = 1'b0;
    logic [1:0] sel = 2'b00;
    logic       scl;
    logic       sda_low;
    logic       sda_oe;
    logic       busy;
    logic [7:0] cfg;
    logic [6:0] dev;
    logic       sda_val;
    int         mismatches = 0;
    int         num_checks = 0;
    int         cycles = 0;
    wire        sda = !sda_low && (!sda_oe || sda_val);

    smb_master_model m (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    smbus_ram_nv_slave #(.ERASE_CYCLES(200)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_val), .sda_oe_o(sda_oe),
        .address_select_high_pin_i(sel[1]), .address_select_low_pin_i(sel[0]),
        .download_done_i(download_done_i), .erase_busy_o(busy),
        .config_update_control_o(cfg)
    );

    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ----------
    // checks and transfers
    // ----------
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic write_tx(input logic [6:0] a, input logic [7:0] b[$], input logic exp);
        logic k;
        m.start_cond();
        m.send_byte({a, 1'b0}, k);
        check_bit("address ack", exp, k);
        for (int i = 0; i < b.size() && k; i++) begin
            m.send_byte(b[i], k);
            check_bit("byte ack", 1'b1, k);
        end
        m.stop_cond();
    endtask
    task automatic read_tx(input logic [7:0] exp);
        logic       k;
        logic [7:0] d;
        m.start_cond();
        m.send_byte({dev, 1'b1}, k);
        check_bit("read address ack", 1'b1, k);
        m.recv_byte(1'b1, d);
        m.stop_cond();
        check_byte("read data", exp, d);
    endtask

    initial begin
        dev = {smb_pkg::SLAVE_ADDR_HI, 2'b11};
        repeat (5) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check_byte("config reset", 8'h00, cfg);
        write_tx({smb_pkg::SLAVE_ADDR_HI, 2'b00}, '{8'h10}, 1'b0);
        download_done_i = 1'b1;
        for (int p = 0; p < 4; p++) begin
            @(negedge ref_clk_i);
            sel = p[1:0];
            repeat (4) @(negedge ref_clk_i);
            write_tx({smb_pkg::SLAVE_ADDR_HI, p[1:0]}, '{8'h10, 8'hA5}, 1'b1);
            write_tx({smb_pkg::SLAVE_ADDR_HI, ~p[1:0]}, '{8'h10}, 1'b0);
        end
        write_tx(dev, '{8'hDF, 8'h3C}, 1'b1);
        write_tx(dev, '{8'hDF}, 1'b1);
        read_tx(8'h3C);
        write_tx(dev, '{8'hE5, 8'h77}, 1'b1);
        write_tx(dev, '{8'h10}, 1'b1);
        read_tx(8'hA5);
        write_tx(dev, '{8'h20}, 1'b1);
        write_tx(dev, '{8'hFC, 8'h02, 8'h11, 8'h22}, 1'b1);
        write_tx(dev, '{8'h20}, 1'b1);
        read_tx(8'h11);
        write_tx(dev, '{8'h21}, 1'b1);
        read_tx(8'h22);
        write_tx(dev, '{8'hF9, 8'h25}, 1'b1);
        write_tx(dev, '{8'hFE}, 1'b1);
        check_bit("erase busy", 1'b0, busy);
        write_tx(dev, '{8'h90, 8'h04}, 1'b1);
        check_byte("config", 8'h04, cfg);
        write_tx(dev, '{8'h90}, 1'b1);
        read_tx(8'h04);
        write_tx(dev, '{8'hF9, 8'h25}, 1'b1);
        write_tx(dev, '{8'hFE}, 1'b1);
        check_bit("erase busy", 1'b1, busy);
        write_tx(dev, '{8'h10}, 1'b0);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge ref_clk_i);
        check_bit("erase done", 1'b0, busy);
        write_tx(dev, '{8'hF9, 8'h25, 8'h5A}, 1'b1);
        write_tx(dev, '{8'hF9, 8'h25, 8'h00}, 1'b1);
        write_tx(dev, '{8'hF9, 8'h25}, 1'b1);
        read_tx(8'h5A);
        write_tx(dev, '{8'hF9, 8'h20}, 1'b1);
        read_tx(8'hFF);
        write_tx(dev, '{8'hF9, 8'h3F}, 1'b1);
        read_tx(8'hFF);
        final_report();
    end
endmodule // smbus_ram_eeprom_access_slave_test
